// file: rtl/sto_pkg.sv
// Purpose: Shared constants and types for the safe torque-off monitor.
// Assumes: 50 MHz system clock; all times converted to cycles or ticks here.
// Notes:   Tick-based timing keeps long intervals in small counters.
package sto_pkg;

	// System clock rate
	localparam int unsigned CLK_HZ         = 50_000_000;
	// Base tick period of the slow timing domain, in microseconds
	localparam int unsigned TICK_TIME_US   = 1000;
	localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1_000_000) * TICK_TIME_US;
	// Allowed channel skew before the card faults, in milliseconds
	localparam int unsigned DISC_TIME_MS   = 1000;
	localparam int unsigned DISC_TICKS     = (DISC_TIME_MS * 1000) / TICK_TIME_US;

	// Fieldbus profile accepted: version code and CRC length in bytes
	localparam logic [7:0]  PROFILE_V26    = 8'h26;
	localparam logic [2:0]  PROFILE_CRC_B  = 3'h4;

	// Multiturn counter width and overspeed limit
	localparam int unsigned MT_WIDTH       = 16;
	localparam logic [15:0] MT_SPEED_RPM   = 16'h1d4c;   // 7500 rpm
	localparam logic [15:0] MT_RESET_VAL   = 16'h0000;

	// Filter cutoff limit in Hz and Q16 gain per Hz at the tick rate
	localparam logic [6:0]  FILT_MAX_HZ    = 7'h4b;      // 75 Hz
	localparam logic [8:0]  FILT_GAIN_Q16  = 9'h19c;     // 2*pi*1ms*65536

	// Encoder emulation sample width and wave table size
	localparam int unsigned EMU_WIDTH      = 8;
	localparam int unsigned WAVE_ADDR_W    = 6;
	localparam logic [5:0]  COS_OFFSET     = 6'h10;      // Quarter period

	// Safety card operating states
	typedef enum logic [1:0] {
		ST_INIT,
		ST_NORMAL,
		ST_SAFE_OP,
		ST_FAULT
	} sto_card_e;

endpackage

// file: rtl/sto_wave_if.sv
// Purpose: Carries the two table lookups of the encoder emulation.
// Assumes: One request per clock, data one clock later.
// Notes:   Sine and cosine share a single table.
`timescale 1ns/10ps
`default_nettype none
interface sto_wave_if;
	import sto_pkg::*;
	logic        [WAVE_ADDR_W-1:0] sin_addr;
	logic        [WAVE_ADDR_W-1:0] cos_addr;
	logic signed [EMU_WIDTH-1:0]   sin_data;
	logic signed [EMU_WIDTH-1:0]   cos_data;

	modport user (output sin_addr, output cos_addr, input sin_data, input cos_data);
	modport rom  (input sin_addr, input cos_addr, output sin_data, output cos_data);
endinterface
`default_nettype wire

// file: rtl/sto_tick_div.sv
// Purpose: Divides the system clock into a one-cycle tick pulse.
// Assumes: CYCLES of at least two.
// Notes:   Every slow timing in the block runs on this enable.
`timescale 1ns/10ps
`default_nettype none
module sto_tick_div #(
	parameter int unsigned CYCLES = 50000
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	localparam int unsigned CW = $clog2(CYCLES);
	logic [CW-1:0] cnt_q;
	wire           wrap = (cnt_q == CW'(CYCLES - 1));

	initial begin
		if (CYCLES < 2) $error("sto_tick_div: CYCLES must be at least 2");
	end

	// Free-running count; tick on wrap
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
			tick_o <= wrap;
		end
	end
endmodule
`default_nettype wire

// file: rtl/sto_wave_rom.sv
// Purpose: Quarter-wave sine table with two registered read ports.
// Assumes: 64 samples per period, 8-bit signed amplitude.
// Notes:   Only a quarter is stored; symmetry rebuilds the rest.
`timescale 1ns/10ps
`default_nettype none
module sto_wave_rom
	import sto_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	sto_wave_if.rom   wave
);
	// First quadrant of sin, 17 points including the peak
	localparam logic [6:0] QTAB [0:16] = '{
		7'h00, 7'h0c, 7'h19, 7'h25, 7'h31, 7'h3c, 7'h47, 7'h51, 7'h5a,
		7'h62, 7'h6a, 7'h70, 7'h75, 7'h7a, 7'h7d, 7'h7e, 7'h7f};

	// Full-period lookup from the quarter table
	function automatic logic signed [EMU_WIDTH-1:0] wave_at(input logic [WAVE_ADDR_W-1:0] a);
		logic [4:0] idx;
		logic [6:0] mag;
		idx = a[4] ? (5'h10 - {1'b0, a[3:0]}) : {1'b0, a[3:0]};
		mag = QTAB[idx];
		wave_at = a[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	endfunction

	// Registered read keeps the outputs glitch free
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wave.sin_data <= '0;
			wave.cos_data <= '0;
		end else begin
			wave.sin_data <= wave_at(wave.sin_addr);
			wave.cos_data <= wave_at(wave.cos_addr);
		end
	end
endmodule
`default_nettype wire

// file: rtl/sto_monitor.sv
// Purpose: Safety card supervision: torque off, brake, faults,
//          encoder emulation, multiturn count and filtered speed.
// Assumes: Channel, reset, supply and return pins are asynchronous and synchronised here; drive
//          control inputs are on mclk_i.
// Notes:   Slow timing runs on a 1 ms tick from sto_tick_div.
`timescale 1ns/10ps
`default_nettype none

//Contract
// - Channel skew over one second faults card
// - Both channels at 0 V activate torque-off
// - Diagnostic output high while torque-off active
// - Torque-off while enabled in loop faults drive
// - Coupled parameter applies brake with torque-off
// - Brake never applied without torque-off
// - Emulation enabled in normal or safe operation
// - Emulation uses configured periods per revolution
// - Card fault forces sine and cosine zero
// - Only profile V2.6, 4-byte CRC accepted
// - Sixteen-bit multiturn counter from single-turn wraps
// - Multiturn counter starts at zero after restart
// - Above 7500 rpm counter clears, invalid flag
// - Filtered speed low-pass cutoff 0 to 75 Hz
// - Single channel: torque only with supply high
// - Two channel: supply and return both required
// - Clear-fault command clears torque-off fault
// - Torque-off with drive disabled sets no fault
// - Normal operation only on reset rising edge; from safe operation, both channels high suffice
// - Status output high when card ready
module sto_monitor
	import sto_pkg::*;
#(
	parameter int unsigned TICK_CYC  = TICK_CYCLES,
	parameter int unsigned DISC_TICK = DISC_TICKS,
	parameter int unsigned POS_WIDTH = 16
) (
	input  wire logic                        mclk_i,
	input  wire logic                        rst_i,
	// Safety card pins
	input  wire logic                        torque_off_chan_a_i,
	input  wire logic                        torque_off_chan_b_i,
	input  wire logic                        card_reset_i,
	// Basic device pins
	input  wire logic                        basic_mode_i,
	input  wire logic                        two_channel_i,
	input  wire logic                        torque_off_supply_i,
	input  wire logic                        torque_off_return_i,
	// Drive control
	input  wire logic                        drive_enabled_i,
	input  wire logic                        closed_loop_i,
	input  wire logic                        clear_fault_i,
	// Safety parameters
	input  wire logic                        couple_brake_to_torque_off_i,
	input  wire logic [7:0]                  emu_periods_i,
	input  wire logic [6:0]                  filter_cutoff_hz_i,
	// Encoder data and fieldbus profile
	input  wire logic [POS_WIDTH-1:0]        safe_position_i,
	input  wire logic signed [15:0]          motor_speed_rpm_i,
	input  wire logic [7:0]                  profile_version_i,
	input  wire logic [2:0]                  profile_crc_bytes_i,
	// Outputs
	output logic                             safe_torque_off_o,
	output logic                             torque_off_diag_o,
	output logic                             safe_brake_control_o,
	output logic                             torque_off_active_fault_o,
	output logic                             drive_enable_permit_o,
	output logic                             torque_permit_o,
	output logic                             card_fault_o,
	output logic                             status_ready_o,
	output logic                             emu_enable_o,
	output logic signed [EMU_WIDTH-1:0]      emu_sin_o,
	output logic signed [EMU_WIDTH-1:0]      emu_cos_o,
	output logic                             link_ok_o,
	output logic [MT_WIDTH-1:0]              multiturn_o,
	output logic                             multiturn_invalid_o,
	output logic signed [15:0]               filtered_speed_o
);

	localparam int unsigned DW = $clog2(DISC_TICK + 2);

	initial begin
		if (TICK_CYC < 2) $error("sto_monitor: TICK_CYC must be at least 2");
		if (DISC_TICK < 1) $error("sto_monitor: DISC_TICK must be at least 1");
		if (POS_WIDTH < 8 || POS_WIDTH > 32) $error("sto_monitor: POS_WIDTH out of range");
	end

	// Pin synchronisers: the first stage feeds only the second
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= {torque_off_return_i, torque_off_supply_i, card_reset_i,
			               torque_off_chan_b_i, torque_off_chan_a_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	wire chan_a     = pin_sync_q[0];
	wire chan_b     = pin_sync_q[1];
	wire rst_pin    = pin_sync_q[2];
	wire sup_pin    = pin_sync_q[3];
	wire ret_pin    = pin_sync_q[4];

	// Reset pin edge; the previous value starts low so a pin held
	// high through power-up counts as an edge once out of reset
	logic rst_pin_q;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) rst_pin_q <= 1'b0;
		else       rst_pin_q <= rst_pin;
	end
	wire ack_rise = rst_pin & ~rst_pin_q;

	// Slow tick
	logic tick;

	sto_tick_div #(
		.CYCLES (TICK_CYC)
	) u_tick (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	// Channel discrepancy timer
	logic [DW-1:0] disc_q;
	wire           chan_differ = chan_a ^ chan_b;
	wire           disc_expire = (disc_q > DW'(DISC_TICK));

	// Counts ticks from the first change until the channels agree, holding once past DISC_TICK
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)              disc_q <= '0;
		else if (!chan_differ)  disc_q <= '0;
		else if (tick && !disc_expire) disc_q <= disc_q + 1'b1;
	end

	// Card state machine
	sto_card_e state_q;
	sto_card_e state_d;

	// Either channel low already requests torque-off; this errs safe
	// during the skew window before the timer decides
	wire sto_req = ~chan_a | ~chan_b;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_INIT: begin
				// Skew is judged while waiting for the acknowledge as well
				if (disc_expire) state_d = ST_FAULT;
				else if (ack_rise && !chan_differ) state_d = sto_req ? ST_SAFE_OP : ST_NORMAL;
			end
			ST_NORMAL: begin
				if (disc_expire)  state_d = ST_FAULT;
				else if (sto_req) state_d = ST_SAFE_OP;
			end
			ST_SAFE_OP: begin
				if (disc_expire)   state_d = ST_FAULT;
				else if (!sto_req) state_d = ST_NORMAL;
			end
			ST_FAULT: begin
				// Leaving the fault needs agreeing channels and a fresh edge
				if (ack_rise && !chan_differ) state_d = sto_req ? ST_SAFE_OP : ST_NORMAL;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) state_q <= ST_INIT;
		else       state_q <= state_d;
	end

	wire card_run = (state_q == ST_NORMAL) || (state_q == ST_SAFE_OP);

	// Torque-off, brake and drive fault
	// Card basic path: supply must be high; in two-channel wiring the
	// return must be closed as well, single-channel ties it to ground
	wire basic_ok   = sup_pin & (ret_pin | ~two_channel_i);
	// Card path: torque only while running with both channels high
	wire card_ok    = (state_q == ST_NORMAL);
	wire sto_active = basic_mode_i ? ~basic_ok : ~card_ok;

	logic sto_q;
	logic fault_q;

	// Fault on torque-off onset while the drive is enabled in loop;
	// a disabled drive (prior shutdown) raises nothing
	wire  sto_rise  = sto_active & ~sto_q;
	wire  fault_set = sto_rise & drive_enabled_i & closed_loop_i;
	// Next fault value; outputs follow it so set and clear show alike
	wire  fault_d   = fault_set | (fault_q & ~clear_fault_i);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sto_q   <= 1'b1;
			fault_q <= 1'b0;
		end else begin
			sto_q   <= sto_active;
			// Set wins over a clear in the same cycle
			if (fault_set)          fault_q <= 1'b1;
			else if (clear_fault_i) fault_q <= 1'b0;
		end
	end

	// Registered status outputs
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			safe_torque_off_o         <= 1'b1;
			torque_off_diag_o         <= 1'b1;
			safe_brake_control_o      <= 1'b0;
			torque_off_active_fault_o <= 1'b0;
			drive_enable_permit_o     <= 1'b0;
			torque_permit_o           <= 1'b0;
			card_fault_o              <= 1'b0;
			status_ready_o            <= 1'b0;
			emu_enable_o              <= 1'b0;
			link_ok_o                 <= 1'b0;
		end else begin
			safe_torque_off_o         <= sto_active;
			torque_off_diag_o         <= sto_active;
			// Brake has no source but torque-off itself
			safe_brake_control_o      <= sto_active & couple_brake_to_torque_off_i;
			torque_off_active_fault_o <= fault_d;
			// Re-enable needs the fault gone and torque-off released
			drive_enable_permit_o     <= ~fault_d & ~sto_active;
			torque_permit_o           <= ~sto_active;
			card_fault_o              <= (state_q == ST_FAULT);
			status_ready_o            <= card_run;
			emu_enable_o              <= card_run;
			link_ok_o                 <= (profile_version_i == PROFILE_V26) &&
			                             (profile_crc_bytes_i == PROFILE_CRC_B);
		end
	end

	// Sine/cosine encoder emulation
	sto_wave_if wave ();

	// Electrical angle is position times periods; only the wrapped
	// fraction of a period matters, so the product is cut to POS_WIDTH
	logic [POS_WIDTH+7:0]   phase_full;
	wire  [POS_WIDTH-1:0]   phase = phase_full[POS_WIDTH-1:0];
	assign phase_full = safe_position_i * emu_periods_i;

	assign wave.sin_addr = phase[POS_WIDTH-1 -: WAVE_ADDR_W];
	assign wave.cos_addr = phase[POS_WIDTH-1 -: WAVE_ADDR_W] + COS_OFFSET;

	sto_wave_rom u_rom (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.wave   (wave)
	);

	// Outside normal or safe operation both outputs sit at zero, so a
	// fault shows to the controller as a collapsed vector
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			emu_sin_o <= '0;
			emu_cos_o <= '0;
		end else if (card_run) begin
			emu_sin_o <= wave.sin_data;
			emu_cos_o <= wave.cos_data;
		end else begin
			emu_sin_o <= '0;
			emu_cos_o <= '0;
		end
	end

	// Safe multiturn counter
	logic [1:0] pos_hi_q;
	wire  [1:0] pos_hi   = safe_position_i[POS_WIDTH-1 -: 2];
	wire        wrap_up  = (pos_hi_q == 2'b11) && (pos_hi == 2'b00);
	wire        wrap_dn  = (pos_hi_q == 2'b00) && (pos_hi == 2'b11);

	// Magnitude of the speed, used only by the overspeed limit
	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		abs16 = v[15] ? 16'(-v) : 16'(v);
	endfunction

	wire overspeed = abs16(motor_speed_rpm_i) > MT_SPEED_RPM;

	// Not retained: counting restarts from zero after every reset.
	// The invalid flag stays until a new acknowledge edge.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pos_hi_q            <= 2'b00;
			multiturn_o         <= MT_RESET_VAL;
			multiturn_invalid_o <= 1'b0;
		end else begin
			pos_hi_q <= pos_hi;
			if (overspeed) begin
				multiturn_o         <= MT_RESET_VAL;
				multiturn_invalid_o <= 1'b1;
			end else begin
				if (wrap_up)      multiturn_o <= multiturn_o + 1'b1;
				else if (wrap_dn) multiturn_o <= multiturn_o - 1'b1;
				if (ack_rise)     multiturn_invalid_o <= 1'b0;
			end
		end
	end

	// Low-pass filtered speed, first order, updated each tick
	wire  [6:0]         fc_hz  = (filter_cutoff_hz_i > FILT_MAX_HZ) ? FILT_MAX_HZ
	                                                             : filter_cutoff_hz_i;
	wire  [15:0]        gain   = 16'(fc_hz) * 16'(FILT_GAIN_Q16);
	logic signed [31:0] acc_q;
	wire  signed [32:0] diff   = 33'(signed'({motor_speed_rpm_i, 16'h0000})) - 33'(acc_q);
	wire  signed [49:0] prod   = diff * $signed({1'b0, gain});
	wire  signed [31:0] step   = 32'(prod >>> 16);

	// Gain is zero at 0 Hz, so the output then holds its last value
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)     acc_q <= '0;
		else if (tick) acc_q <= acc_q + step;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) filtered_speed_o <= '0;
		else       filtered_speed_o <= acc_q[31:16];
	end

endmodule
`default_nettype wire

// file: test/sto_ctl_model.sv
// Purpose: Behavioural safety controller driving the card pins.
// Assumes: Requests from the bench arrive on mclk_i.
// Notes:   Channel B lags channel A by a bench-set number of cycles.
`timescale 1ns/10ps
`default_nettype none
module sto_ctl_model (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        off_req_i,
	input  wire logic [15:0] skew_cyc_i,
	input  wire logic        ack_i,
	output logic             chan_a_o,
	output logic             chan_b_o,
	output logic             card_reset_o
);
	logic [15:0] lag_q;
	wire         b_done = (chan_b_o == !off_req_i);

	// Both channels idle at 24 V; a stop request drops them, B after the lag
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			chan_a_o     <= 1'b1;
			chan_b_o     <= 1'b1;
			lag_q        <= 16'h0000;
			card_reset_o <= 1'b0;
		end else begin
			chan_a_o     <= !off_req_i;
			card_reset_o <= ack_i;
			lag_q        <= b_done ? 16'h0000 : lag_q + 16'h0001;
			if (!b_done && lag_q >= skew_cyc_i)
				chan_b_o <= !off_req_i;
		end
	end
endmodule
`default_nettype wire

// file: test/sto_monitor_chk.sv
// Purpose: Port-level assertions for the safe torque-off monitor.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Pins reach the outputs four edges late, hence the skew slack.
`timescale 1ns/10ps
`default_nettype none
module sto_monitor_chk
	import sto_pkg::*;
#(
	parameter int unsigned TICK_CYC  = 10,
	parameter int unsigned DISC_TICK = 4
) (
	input wire logic                    mclk_i,
	input wire logic                    rst_i,
	input wire logic                    torque_off_chan_a_i,
	input wire logic                    torque_off_chan_b_i,
	input wire logic                    drive_enabled_i,
	input wire logic                    closed_loop_i,
	input wire logic                    clear_fault_i,
	input wire logic                    couple_brake_to_torque_off_i,
	input wire logic signed [15:0]      motor_speed_rpm_i,
	input wire logic [7:0]              profile_version_i,
	input wire logic [2:0]              profile_crc_bytes_i,
	input wire logic                    safe_torque_off_o,
	input wire logic                    torque_off_diag_o,
	input wire logic                    safe_brake_control_o,
	input wire logic                    torque_off_active_fault_o,
	input wire logic                    card_fault_o,
	input wire logic                    status_ready_o,
	input wire logic                    emu_enable_o,
	input wire logic signed [EMU_WIDTH-1:0] emu_sin_o,
	input wire logic signed [EMU_WIDTH-1:0] emu_cos_o,
	input wire logic                    link_ok_o,
	input wire logic [MT_WIDTH-1:0]     multiturn_o,
	input wire logic                    multiturn_invalid_o
);
	// Tick rounding plus sync latency bound the skew fault moment
	localparam int LIM = (DISC_TICK + 2) * TICK_CYC + 6;
	logic [15:0] skew_q;
	wire  [15:0] skew_d = (torque_off_chan_a_i == torque_off_chan_b_i) ? 16'h0000 :
		((skew_q == 16'hffff) ? skew_q : skew_q + 16'h0001);
	wire         over_spd = (motor_speed_rpm_i > $signed(MT_SPEED_RPM)) || (motor_speed_rpm_i < -$signed(MT_SPEED_RPM));
	wire         link_good = (profile_version_i == PROFILE_V26) && (profile_crc_bytes_i == PROFILE_CRC_B);

	// Cycles the raw channel pins have disagreed
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			skew_q <= 16'h0000;
		else
			skew_q <= skew_d;
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_off_rise;
		$rose(safe_torque_off_o);
	endsequence
	sequence s_off_coupled;
		s_off_rise ##0 $past(couple_brake_to_torque_off_i);
	endsequence
	sequence s_off_in_loop;
		s_off_rise ##0 $past(drive_enabled_i && closed_loop_i);
	endsequence
	sequence s_off_idle;
		s_off_rise ##0 (!$past(drive_enabled_i) && !$past(torque_off_active_fault_o));
	endsequence

	AST_DIAG: assert property (torque_off_diag_o == safe_torque_off_o)
		else $error("diag output differs from torque-off state");
	AST_BRAKE_ONLY: assert property (safe_brake_control_o |-> safe_torque_off_o)
		else $error("brake applied without torque-off");
	AST_BRAKE_COUPLE: assert property (s_off_coupled |-> safe_brake_control_o)
		else $error("coupled brake missing at torque-off");
	AST_FAULT_SET: assert property (s_off_in_loop |-> torque_off_active_fault_o)
		else $error("drive fault missing at torque-off in control");
	AST_NO_FAULT: assert property (s_off_idle |-> !torque_off_active_fault_o)
		else $error("drive fault set with drive disabled");
	AST_CLEAR: assert property (torque_off_active_fault_o && clear_fault_i && safe_torque_off_o |=> !torque_off_active_fault_o)
		else $error("clear-fault did not clear drive fault");
	AST_EMU_ZERO: assert property (card_fault_o && $past(card_fault_o) |-> emu_sin_o == '0 && emu_cos_o == '0)
		else $error("emulation not zero in card fault");
	AST_EMU_EN: assert property (emu_enable_o == (status_ready_o && !card_fault_o))
		else $error("emulation enable wrong for card state");
	AST_MT_OVER: assert property (over_spd |=> multiturn_o == '0 && multiturn_invalid_o)
		else $error("overspeed did not clear multiturn count");
	AST_LINK: assert property (1'b1 |=> link_ok_o == $past(link_good))
		else $error("link status wrong for offered profile");
	AST_DISC: assert property (int'(skew_q) == LIM |-> card_fault_o)
		else $error("channel skew did not fault the card");
endmodule

bind sto_monitor sto_monitor_chk #(
	.TICK_CYC (TICK_CYC),
	.DISC_TICK(DISC_TICK)
) u_sto_monitor_chk (
	.mclk_i, .rst_i, .torque_off_chan_a_i, .torque_off_chan_b_i, .drive_enabled_i, .closed_loop_i,
	.clear_fault_i, .couple_brake_to_torque_off_i, .motor_speed_rpm_i, .profile_version_i, .profile_crc_bytes_i,
	.safe_torque_off_o, .torque_off_diag_o, .safe_brake_control_o, .torque_off_active_fault_o, .card_fault_o,
	.status_ready_o, .emu_enable_o, .emu_sin_o, .emu_cos_o, .link_ok_o, .multiturn_o, .multiturn_invalid_o
);
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for the safe torque-off monitor.
// Assumes: Short tick (10 cycles) and skew limit (4 ticks) for speed.
// Notes:   Card pins come from the controller model; the rest from here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp); end end
module tb;
	import sto_pkg::*;
	logic mclk_i, rst_i, torque_off_chan_a_i, torque_off_chan_b_i, card_reset_i, off_req, ack;
	logic basic_mode_i, two_channel_i, torque_off_supply_i, torque_off_return_i;
	logic drive_enabled_i, closed_loop_i, clear_fault_i, couple_brake_to_torque_off_i;
	logic [7:0] emu_periods_i, profile_version_i;
	logic [6:0] filter_cutoff_hz_i;
	logic [2:0] profile_crc_bytes_i;
	logic [15:0] safe_position_i, skew;
	logic signed [15:0] motor_speed_rpm_i, filtered_speed_o;
	logic safe_torque_off_o, torque_off_diag_o, safe_brake_control_o, torque_off_active_fault_o;
	logic drive_enable_permit_o, torque_permit_o, card_fault_o, status_ready_o, emu_enable_o;
	logic link_ok_o, multiturn_invalid_o;
	logic signed [EMU_WIDTH-1:0] emu_sin_o, emu_cos_o;
	logic [MT_WIDTH-1:0] multiturn_o;
	int fails, total_checks;

	sto_monitor #(.TICK_CYC(10), .DISC_TICK(4)) u_sto_monitor (
		.mclk_i, .rst_i, .torque_off_chan_a_i, .torque_off_chan_b_i, .card_reset_i, .basic_mode_i, .two_channel_i,
		.torque_off_supply_i, .torque_off_return_i, .drive_enabled_i, .closed_loop_i, .clear_fault_i,
		.couple_brake_to_torque_off_i, .emu_periods_i, .filter_cutoff_hz_i, .safe_position_i, .motor_speed_rpm_i,
		.profile_version_i, .profile_crc_bytes_i, .safe_torque_off_o, .torque_off_diag_o, .safe_brake_control_o,
		.torque_off_active_fault_o, .drive_enable_permit_o, .torque_permit_o, .card_fault_o, .status_ready_o,
		.emu_enable_o, .emu_sin_o, .emu_cos_o, .link_ok_o, .multiturn_o, .multiturn_invalid_o, .filtered_speed_o
	);
	sto_ctl_model u_sto_ctl_model (
		.mclk_i(mclk_i), .rst_i(rst_i), .off_req_i(off_req), .skew_cyc_i(skew), .ack_i(ack),
		.chan_a_o(torque_off_chan_a_i), .chan_b_o(torque_off_chan_b_i), .card_reset_o(card_reset_i)
	);

	// 50 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	// Waits settle past the edge so outputs are read after they land
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic pulse_ack();
		@(posedge mclk_i) ack <= 1'b1;
		wt(3);
		@(posedge mclk_i) ack <= 1'b0;
		wt(10);
	endtask
	task automatic stop(input logic on, input logic [15:0] lag, input int n);
		@(posedge mclk_i) begin
			skew    <= lag;
			off_req <= on;
		end
		wt(n);
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		fails = 0; total_checks = 0; rst_i = 1'b1; off_req = 1'b0; ack = 1'b0; skew = 16'h0000;
		basic_mode_i = 1'b0; two_channel_i = 1'b0; torque_off_supply_i = 1'b0; torque_off_return_i = 1'b0;
		drive_enabled_i = 1'b0; closed_loop_i = 1'b0; clear_fault_i = 1'b0; couple_brake_to_torque_off_i = 1'b1;
		emu_periods_i = 8'h02; filter_cutoff_hz_i = 7'h00; safe_position_i = 16'h0000;
		motor_speed_rpm_i = 16'sh0000; profile_version_i = 8'h26; profile_crc_bytes_i = 3'h4;
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		wt(2);
		`CHK(multiturn_o, 16'h0000)
		`CHK(status_ready_o, 1'b0)
		pulse_ack();
		`CHK({status_ready_o, emu_enable_o, torque_off_diag_o}, 3'h6)
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk_i) begin
				profile_version_i   <= (i == 1) ? 8'h25 : 8'h26;
				profile_crc_bytes_i <= (i == 2) ? 3'h2 : 3'h4;
			end
			wt(2);
			`CHK(link_ok_o, (i == 0))
		end
		@(posedge mclk_i) begin
			drive_enabled_i <= 1'b1;
			closed_loop_i   <= 1'b1;
		end
		stop(1'b1, 16'h0000, 8);
		`CHK({safe_torque_off_o, torque_off_diag_o, safe_brake_control_o}, 3'h7)
		`CHK({torque_off_active_fault_o, drive_enable_permit_o}, 2'h2)
		@(posedge mclk_i) clear_fault_i <= 1'b1;
		@(posedge mclk_i) clear_fault_i <= 1'b0;
		wt(2);
		`CHK(torque_off_active_fault_o, 1'b0)
		stop(1'b0, 16'h0000, 8);
		`CHK(drive_enable_permit_o, 1'b1)
		@(posedge mclk_i) begin
			drive_enabled_i              <= 1'b0;
			couple_brake_to_torque_off_i <= 1'b0;
		end
		stop(1'b1, 16'h0000, 8);
		`CHK({safe_torque_off_o, torque_off_active_fault_o}, 2'h2)
		`CHK(safe_brake_control_o, 1'b0)
		stop(1'b0, 16'h0000, 8);
		`CHK(drive_enable_permit_o, 1'b1)
		stop(1'b1, 16'h0014, 60);
		`CHK(card_fault_o, 1'b0)
		stop(1'b0, 16'h0014, 60);
		`CHK(card_fault_o, 1'b0)
		stop(1'b1, 16'h00c8, 120);
		`CHK({card_fault_o, status_ready_o}, 2'h2)
		`CHK({emu_sin_o, emu_cos_o}, 16'h0000)
		wt(100);
		pulse_ack();
		`CHK({card_fault_o, status_ready_o, safe_torque_off_o}, 3'h3)
		stop(1'b0, 16'h0000, 8);
		`CHK(safe_torque_off_o, 1'b0)
		@(posedge mclk_i) safe_position_i <= 16'h2000;
		wt(4);
		`CHK({emu_sin_o, emu_cos_o}, 16'h7f00)
		`CHK(emu_sin_o * emu_sin_o + emu_cos_o * emu_cos_o > 16000, 1'b1)
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk_i) safe_position_i <= (i == 0) ? 16'h8000 : ((i[0] == 1'b1) ? 16'hc000 : 16'h0000);
			wt(3);
			if (i >= 2)
				`CHK(multiturn_o, {15'h0000, i[0] == 1'b0})
		end
		@(posedge mclk_i) motor_speed_rpm_i <= 16'sh1d4d;
		wt(2);
		`CHK({multiturn_o, multiturn_invalid_o}, 17'h00001)
		@(posedge mclk_i) motor_speed_rpm_i <= 16'sh1d4c;
		pulse_ack();
		`CHK({multiturn_invalid_o, filtered_speed_o}, 17'h00000)
		@(posedge mclk_i) filter_cutoff_hz_i <= 7'h4b;
		wt(300);
		`CHK(filtered_speed_o > 16'sh1d00 && filtered_speed_o <= 16'sh1d4c, 1'b1)
		@(posedge mclk_i) basic_mode_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_i) {two_channel_i, torque_off_supply_i, torque_off_return_i} <= 3'(i);
			wt(5);
			`CHK(torque_permit_o, i[1] & (i[0] | !i[2]))
		end
		test_done();
	end

	// Whole run needs about 830 cycles; six times that means a hang
	initial begin
		repeat (5000) @(posedge mclk_i);
		fails++;
		test_done();
	end
endmodule
`default_nettype wire
